// file: lrd_line_receiver.sv
// Receive back end: control, lock, decoder, loss of signal, muting
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
// Summary of operation
// R1 - Equalizer enable control steers equalizer path
// R2 - Controller disables equalizer for short hot pulses; not done here, equalizerEnable only follows cfg[CTL_EQ]
// R3 - Monitor gain bit or pin enables gain
// R4 - Declare lock loss on absence or offset
// R5 - Lock loss outputs reference clock
// R6 - Lock present outputs recovered line clock
// R7 - Decode B3ZS or HDB3 by rate
// R8 - Pulse code violation on bad bipolar, zeros
// R9 - Dual-rail format bypasses decoder
// R10 - Digital loss after 175 consecutive zeros
// R11 - Clear digital loss above 33 percent density
// R12 - Analog loss status reported, threshold selected
// R13 - Receive loss is digital OR analog
// R14 - Both disables turn off loss detection
// R15 - E3 loss after run below threshold
// R16 - E3 loss clears within 10-255 UI
// R17 - Loss selects reference or synthesized clock
// R18 - Mute data during loss when enabled
// R19 - Resume data after loss clears
// R20 - Host select chooses registers over pins
// R21 - Zero-run counter restarts on each pulse
module lrd_line_receiver
   import lrd_pkg::*;
(
   input  wire logic                  core_clk,       // System clock
   input  wire logic                  rst_n,          // Sync reset
   input  wire logic [7:0]            regAddr,        // Register address
   input  wire logic [31:0]           regWdata,       // Write data
   input  wire logic                  regWr,          // Write strobe
   input  wire logic                  regRd,          // Read strobe
   output logic [31:0]                regRdata,       // Read data
   input  wire logic                  selectA,        // High: host mode
   input  wire logic [lrd_pkg::CTL_WIDTH-1:0] ctlPins, // Hardware pins
   input  wire lrd_pkg::lrd_sym_t     lineSym,        // Retimed symbol
   input  wire logic                  lineBitStb,     // One per bit
   input  wire logic                  signalPresent,  // Analog detect
   input  wire logic                  analogBelow,    // Below threshold
   input  wire logic                  refTick,        // Reference tick
   input  wire logic                  recTick,        // Recovered tick
   output logic                       equalizerEnable,   // Eq in path
   output logic                       monitorGainEnable, // Extra gain
   output logic                       losThresholdSelect, // Thr pick
   output lrd_pkg::lrd_cksel_t        clockSelect,    // Clock source
   output logic                       lockLoss,       // Loss of lock
   output logic                       receiveLos,     // Receive LOS
   output logic                       codeViolationPulse, // Violation
   output lrd_pkg::lrd_sym_t          rxData          // Output data
);
   import lrd_pkg::*;

   // Pin inputs through three flops
   logic [2:0] selSync;
   logic [2:0] presSync;
   logic [2:0] belowSync;
   logic [2:0] refSync;
   logic [2:0] recSync;
   logic [CTL_WIDTH-1:0] pin1, pin2, pin3;
   always_ff @(posedge core_clk) begin
      selSync   <= {selSync[1:0], selectA};
      presSync  <= {presSync[1:0], signalPresent};
      belowSync <= {belowSync[1:0], analogBelow};
      refSync   <= {refSync[1:0], refTick};
      recSync   <= {recSync[1:0], recTick};
      pin1 <= ctlPins;
      pin2 <= pin1;
      pin3 <= pin2;
   end

   // Filtered levels accepted when second and third agree
   logic hostMode_reg, present_reg, below_reg;
   logic [CTL_WIDTH-1:0] pins_reg;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         hostMode_reg <= 1'b0;
         present_reg  <= 1'b0;
         below_reg    <= 1'b0;
         pins_reg     <= CTL_RESET;
      end else begin
         if (selSync[1] == selSync[2]) hostMode_reg <= selSync[2];
         if (presSync[1] == presSync[2]) present_reg <= presSync[2];
         if (belowSync[1] == belowSync[2]) below_reg <= belowSync[2];
         if (pin2 == pin3) pins_reg <= pin3;
      end
   end

   // Control register written by software
   logic [CTL_WIDTH-1:0] ctl_reg;
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         ctl_reg <= CTL_RESET;
      else if (regWr && regAddr == LRD_ADDR_CTRL)
         ctl_reg <= regWdata[CTL_WIDTH-1:0];
   end

   // Effective configuration source
   logic [CTL_WIDTH-1:0] cfg;
   assign cfg = hostMode_reg ? ctl_reg : pins_reg; // R20
   logic [1:0] rate;
   assign rate = cfg[CTL_RATE0 +: 2];
   logic isE3;
   assign isE3 = (rate == RATE_E3);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         equalizerEnable    <= 1'b0;
         monitorGainEnable  <= 1'b0;
         losThresholdSelect <= 1'b0;
      end else begin
         equalizerEnable    <= cfg[CTL_EQ];                     // R1
         monitorGainEnable  <= hostMode_reg ?                   // R3
            (ctl_reg[CTL_MON] | pins_reg[CTL_MON]) : pins_reg[CTL_MON];
         losThresholdSelect <= cfg[CTL_THR];                    // R12
      end
   end

   // Frequency compare over a window of reference ticks
   function automatic logic [15:0] absDiff(input logic [15:0] a,
                                           input logic [15:0] b);
      absDiff = (a > b) ? a - b : b - a;
   endfunction
   logic refEdge, recEdge;
   assign refEdge = refSync[1] & ~refSync[2];
   assign recEdge = recSync[1] & ~recSync[2];
   logic [15:0] refCnt_reg, recCnt_reg;
   logic freqBad_reg;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         refCnt_reg  <= 16'h0000;
         recCnt_reg  <= 16'h0000;
         freqBad_reg <= 1'b1;
      end else if (refEdge && refCnt_reg == FREQ_WIN - 16'd1) begin
         freqBad_reg <= absDiff(recCnt_reg + 16'(recEdge), FREQ_WIN)
                        > 16'(FREQ_WIN / LOCK_PPT_DIV);     // R4
         refCnt_reg  <= 16'h0000;
         recCnt_reg  <= 16'h0000;
      end else begin
         refCnt_reg <= refCnt_reg + 16'(refEdge);
         recCnt_reg <= recCnt_reg + 16'(recEdge);
      end
   end

   // Loss of lock
   always_ff @(posedge core_clk) begin
      if (!rst_n) lockLoss <= 1'b1;
      else        lockLoss <= ~present_reg | freqBad_reg; // R4
   end

   // Shortest zero gap ahead of the V of a valid substitution
   function automatic logic [1:0] minGap(input logic e3);
      minGap = e3 ? 2'(HDB3_RUN - 2) : 2'(B3ZS_RUN - 2);
   endfunction

   // Zeros already counted when a bit makes the run excessive
   function automatic logic [7:0] runLimit(input logic e3);
      runLimit = e3 ? 8'(HDB3_RUN - 1) : 8'(B3ZS_RUN - 1);
   endfunction

   // Decoder: zero run and bipolar history
   logic mark;
   assign mark = lineSym.pos ^ lineSym.neg;
   logic lastPol_reg;    // Polarity of last pulse, 1 = positive
   logic [7:0] zeroRun_reg;
   logic [1:0] gap_reg;  // Zeros since last pulse, saturating
   logic cv_next, isViol, goodViol;
   assign isViol   = mark && (lineSym.pos == lastPol_reg);
   // A V after too short a gap cannot close a substitution
   assign goodViol = isViol && (gap_reg >= minGap(isE3));   // R7
   always_comb begin
      cv_next = 1'b0;
      if (lineBitStb && !cfg[CTL_DUAL]) begin                 // R9
         if (lineSym.pos && lineSym.neg)
            cv_next = 1'b1;
         else if (isViol)                                     // R8
            cv_next = !goodViol;
         else if (!mark)
            cv_next = (zeroRun_reg == runLimit(isE3));        // R8
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         lastPol_reg <= 1'b0;
         gap_reg     <= 2'h0;
         codeViolationPulse <= 1'b0;
      end else begin
         codeViolationPulse <= cv_next;                        // R8
         if (lineBitStb) begin
            if (mark) begin
               lastPol_reg <= lineSym.pos;
               gap_reg     <= 2'h0;
            end else if (gap_reg != 2'h3)
               gap_reg <= gap_reg + 2'h1;
         end
      end
   end

   // Zero-run counter, restarts on every pulse
   always_ff @(posedge core_clk) begin
      if (!rst_n) zeroRun_reg <= 8'h00;
      else if (lineBitStb) begin
         if (mark) zeroRun_reg <= 8'h00;                       // R21
         else if (zeroRun_reg != 8'hff)
            zeroRun_reg <= zeroRun_reg + 8'h01;
      end
   end

   // Substitution removal: decoded marks wait in a short line so
   // that the B leading a B0V or B00V is erased when its V arrives
   logic [HDB3_RUN-1:0] hist_reg;   // Newest bit in position 0
   logic [HDB3_RUN-1:0] histClr;
   always_comb begin
      histClr = hist_reg;
      if (goodViol && gap_reg == minGap(isE3))
         histClr[gap_reg] = 1'b0;                              // R7
   end

   // History shifts once per line bit; violations enter as zeros
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         hist_reg <= '0;
      else if (lineBitStb)
         hist_reg <= {histClr[HDB3_RUN-2:0], mark & ~isViol};  // R7
   end

   // Decoded output: fixed delay of one HDB3 substitution length
   lrd_sym_t dec_next;
   always_comb begin
      if (cfg[CTL_DUAL])
         dec_next = lineSym;                                   // R9
      else
         dec_next = '{pos: hist_reg[HDB3_RUN-1], neg: 1'b0};   // R7
   end

   // Digital LOS with density window
   logic dlos_reg;
   logic [7:0] winCnt_reg, pulseCnt_reg;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dlos_reg     <= 1'b1;
         winCnt_reg   <= 8'h00;
         pulseCnt_reg <= 8'h00;
      end else if (lineBitStb) begin
         if (!dlos_reg) begin
            winCnt_reg   <= 8'h00;
            pulseCnt_reg <= 8'h00;
            if (!mark && zeroRun_reg == DLOS_ZEROS - 8'd1)
               dlos_reg <= 1'b1;                               // R10
         end else if (winCnt_reg == DLOS_WINDOW - 8'd1) begin
            if (pulseCnt_reg + 8'(mark) > DLOS_PULSES)
               dlos_reg <= 1'b0;                               // R11
            winCnt_reg   <= 8'h00;
            pulseCnt_reg <= 8'h00;
         end else begin
            winCnt_reg   <= winCnt_reg + 8'h01;
            pulseCnt_reg <= pulseCnt_reg + 8'(mark);
         end
      end
   end

   // E3 LOS: count a run of bits with the below-threshold level changed, restarting on any bit that matches
   logic e3los_reg;
   logic [7:0] e3Cnt_reg;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         e3los_reg <= 1'b1;
         e3Cnt_reg <= 8'h00;
      end else if (lineBitStb) begin
         if (below_reg == e3los_reg)
            e3Cnt_reg <= 8'h00;
         else if (e3Cnt_reg == E3_LOS_UI - 8'd1) begin
            e3los_reg <= below_reg;                            // R15 R16
            e3Cnt_reg <= 8'h00;
         end else
            e3Cnt_reg <= e3Cnt_reg + 8'h01;
      end
   end

   // Combined LOS
   logic losOff, alos, losNow;
   assign losOff = cfg[CTL_ADIS] & cfg[CTL_DDIS];              // R14
   assign alos   = below_reg;                                  // R12
   assign losNow = ~losOff & (isE3 ? e3los_reg : (dlos_reg | alos)); // R13
   always_ff @(posedge core_clk) begin
      if (!rst_n) receiveLos <= 1'b0;
      else        receiveLos <= losNow;                        // R13
   end

   // Clock select
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         clockSelect <= CKS_REF;
      else if (receiveLos)
         clockSelect <= cfg[CTL_SFM] ? CKS_SYNTH : CKS_REF;    // R17
      else if (lockLoss)
         clockSelect <= CKS_REF;                               // R5
      else
         clockSelect <= CKS_LINE;                              // R6
   end

   // Data output with muting
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         rxData <= '0;
      else if (lineBitStb) begin
         if (losNow && cfg[CTL_MUTE])
            rxData <= '0;                                      // R18
         else
            rxData <= dec_next;                                // R19
      end
   end

   // Register read
   always_ff @(posedge core_clk) begin
      if (!rst_n)
         regRdata <= 32'h0000_0000;
      else if (regRd) begin
         unique case (regAddr)
            LRD_ADDR_CTRL:   regRdata <= {22'h0, ctl_reg};
            LRD_ADDR_STATUS: regRdata <= {28'h0, receiveLos, alos,
                                          dlos_reg, lockLoss};
            LRD_ADDR_FREQ:   regRdata <= {16'h0, recCnt_reg};
            default:         regRdata <= 32'h0000_0000;
         endcase
      end else
         regRdata <= 32'h0000_0000;
   end

   // Checks
   AST_MUTE: assert property (@(posedge core_clk) disable iff (!rst_n) // R18
      (lineBitStb && losNow && cfg[CTL_MUTE]) |=> rxData == '0)
      else $error("data not muted");
   AST_LOSOR: assert property (@(posedge core_clk) disable iff (!rst_n) // R13
      (!losOff && !isE3 && alos) |=> receiveLos)
      else $error("los not asserted");
   AST_LOSDIS: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
      losOff |=> !receiveLos)
      else $error("los while disabled");
   AST_CKSEL: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
      (lockLoss && !receiveLos) |=> clockSelect == CKS_REF)
      else $error("bad clock select");
   AST_DUAL: assert property (@(posedge core_clk) disable iff (!rst_n) // R9
      cfg[CTL_DUAL] |=> !codeViolationPulse)
      else $error("violation in dual rail");
   AST_ZRST: assert property (@(posedge core_clk) disable iff (!rst_n) // R21
      (lineBitStb && mark) |=> zeroRun_reg == 8'h00)
      else $error("zero run not reset");
   AST_LOCK: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
      !present_reg |=> lockLoss)
      else $error("lock loss missing");
   AST_EQ: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
      $past(rst_n) |-> equalizerEnable == $past(cfg[CTL_EQ]))
      else $error("equalizer mismatch");

   // Clock source checks
   AST_SYNTH: assert property (@(posedge core_clk) disable iff (!rst_n) // R17
      (receiveLos && cfg[CTL_SFM]) |=> clockSelect == CKS_SYNTH)
      else $error("synthesized clock not selected");
   AST_LINE: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
      (!receiveLos && !lockLoss) |=> clockSelect == CKS_LINE)
      else $error("line clock not selected");

   // Loss-of-signal checks
   AST_DLOS: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
      (lineBitStb && !mark && zeroRun_reg == DLOS_ZEROS - 8'd1) |=> dlos_reg)
      else $error("digital loss not declared");

   // Decoder checks: the offending bit, then the flag pulse
   sequence seqRunEnd;
      lineBitStb && !cfg[CTL_DUAL] && !mark && zeroRun_reg == runLimit(isE3);
   endsequence
   sequence seqBadViol;
      lineBitStb && !cfg[CTL_DUAL] && isViol && !goodViol;
   endsequence
   sequence seqFlag;
      codeViolationPulse;
   endsequence
   AST_ZEROS: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
      seqRunEnd |=> seqFlag)
      else $error("excessive zeros not flagged");
   AST_VIOL: assert property (@(posedge core_clk) disable iff (!rst_n) // R8
      seqBadViol |=> seqFlag)
      else $error("bad violation not flagged");
endmodule

// file: lrd_pkg.sv
// Package for the line receiver decode and loss-of-signal block
package lrd_pkg;
   // Register map, byte addresses
   localparam logic [7:0] LRD_ADDR_CTRL   = 8'h00;
   localparam logic [7:0] LRD_ADDR_STATUS = 8'h04;
   localparam logic [7:0] LRD_ADDR_FREQ   = 8'h08;
   // Control bit positions
   localparam int CTL_EQ    = 0;
   localparam int CTL_MON   = 1;
   localparam int CTL_THR   = 2;
   localparam int CTL_ADIS  = 3;
   localparam int CTL_DDIS  = 4;
   localparam int CTL_MUTE  = 5;
   localparam int CTL_SFM   = 6;
   localparam int CTL_DUAL  = 7;
   localparam int CTL_RATE0 = 8;
   localparam int CTL_WIDTH = 10;
   localparam logic [CTL_WIDTH-1:0] CTL_RESET = 10'h001;
   // Status bit positions
   localparam int ST_LOL  = 0;
   localparam int ST_DLOS = 1;
   localparam int ST_ALOS = 2;
   localparam int ST_RLOS = 3;
   // Rate codes
   localparam logic [1:0] RATE_DS3  = 2'h0;
   localparam logic [1:0] RATE_STS1 = 2'h1;
   localparam logic [1:0] RATE_E3   = 2'h2;
   // Loss-of-signal counts, in line bit periods
   localparam logic [7:0] DLOS_ZEROS  = 8'd175;
   localparam logic [7:0] DLOS_WINDOW = 8'd175;
   localparam logic [7:0] DLOS_PULSES = 8'd58; // Just above 33 percent
   localparam logic [7:0] E3_LOS_UI   = 8'd32;
   // Lock tolerance: 0.5 percent as one part in 200
   localparam int LOCK_PPT_DIV = 200;
   localparam logic [15:0] FREQ_WIN = 16'd4000; // Reference ticks per window
   // Zero runs that a substitution replaces: B3ZS, HDB3
   localparam int B3ZS_RUN = 3;
   localparam int HDB3_RUN = 4;
   // Line symbol bundle
   typedef struct packed {
      logic pos;
      logic neg;
   } lrd_sym_t;
   // Selections for the recovered clock output
   typedef enum logic [2:0] {
      CKS_LINE  = 3'b001,
      CKS_REF   = 3'b010,
      CKS_SYNTH = 3'b100
   } lrd_cksel_t;
endpackage

// file: lrd_line_model.sv
// Far-end line model: symbols, bit strobe, energy and clock ticks
`timescale 1ns/1ns
module lrd_line_model
   import lrd_pkg::*;
(
   input  wire logic        core_clk,      // System clock
   input  wire logic [1:0]  mode,          // 0 silent, 1 ones, 2 gaps, 3 bad
   output lrd_pkg::lrd_sym_t lineSym,      // Retimed symbol
   output logic             lineBitStb,    // One pulse per bit
   output logic             signalPresent, // Energy on line
   output logic             refTick,       // Reference tick
   output logic             recTick        // Recovered tick
);
   import lrd_pkg::*;
   logic [1:0] phase;
   logic [2:0] bitIdx;
   logic       polar;
   initial begin
      phase = '0; bitIdx = '0; polar = 1'b0; lineSym = '0;
      lineBitStb = 1'b0; signalPresent = 1'b0; refTick = 1'b0;
      recTick = 1'b0;
   end
   // One bit every four cycles; in modes 1 and 2 marks alternate polarity as AMI
   always @(posedge core_clk) begin
      phase         <= phase + 2'h1;
      lineBitStb    <= (phase == 2'h3);
      refTick       <= phase[1];
      recTick       <= phase[1] & (mode != 2'h0);
      signalPresent <= (mode != 2'h0);
      if (phase == 2'h3) begin
         bitIdx <= bitIdx + 3'h1;
         // Mode 2 leaves four unsubstituted zeros every eight bits;
         // mode 3 repeats one polarity, so every mark is a violation
         if (mode == 2'h3) begin
            lineSym <= lrd_sym_t'(2'h2);
         end else if (mode == 2'h1 || (mode == 2'h2 && !bitIdx[2])) begin
            lineSym <= lrd_sym_t'(polar ? 2'h1 : 2'h2);
            polar   <= ~polar;
         end else begin
            lineSym <= '0;
         end
      end else begin
         lineSym <= ~lineSym; // Not held between strobes
      end
   end
endmodule

// file: test_line_receiver_decode_los.sv
// Self-checking bench for the line receiver decode block
`timescale 1ns/1ns
module test_line_receiver_decode_los;
   import lrd_pkg::*;
   logic core_clk, rst_n, regWr, regRd, selectA, analogBelow, rdDly, seen;
   logic [7:0]  regAddr;
   logic [31:0] regWdata, regRdata, e, m;
   logic [CTL_WIDTH-1:0] ctlPins;
   logic [1:0]  mode;
   lrd_sym_t    lineSym, rxData;
   lrd_cksel_t  clockSelect;
   logic lineBitStb, signalPresent, refTick, recTick, eqEn, monEn, thrSel;
   logic lockLoss, receiveLos, codeViolationPulse;
   logic [31:0] expQ[$], mskQ[$];
   int mismatches = 0, nCompared = 0, cycles = 0, n, seed = 85469;
   lrd_line_receiver DUT (.core_clk(core_clk), .rst_n(rst_n),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .selectA(selectA), .ctlPins(ctlPins),
      .lineSym(lineSym), .lineBitStb(lineBitStb),
      .signalPresent(signalPresent), .analogBelow(analogBelow),
      .refTick(refTick), .recTick(recTick), .equalizerEnable(eqEn),
      .monitorGainEnable(monEn), .losThresholdSelect(thrSel),
      .clockSelect(clockSelect), .lockLoss(lockLoss),
      .receiveLos(receiveLos), .codeViolationPulse(codeViolationPulse),
      .rxData(rxData));
   lrd_line_model line (.core_clk(core_clk), .mode(mode), .lineSym(lineSym),
      .lineBitStb(lineBitStb), .signalPresent(signalPresent),
      .refTick(refTick), .recTick(recTick));
   // Clock generation
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task stop_test;
      $display("compared %0d mismatches %0d", nCompared, mismatches);
      if (mismatches == 0 && nCompared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic ok, input string msg);
      nCompared++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regAddr <= a; regWdata <= d; regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask
   // Read notes its expectation; the watcher compares it
   task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k);
      expQ.push_back(x); mskQ.push_back(k);
      @(posedge core_clk);
      regAddr <= a; regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
   endtask
   // Read data watcher, one cycle after the strobe
   always @(posedge core_clk) begin
      if (rdDly) begin
         e = expQ.pop_front(); m = mskQ.pop_front(); nCompared++;
         if ((regRdata & m) !== e) begin
            mismatches++;
            $display("BAD %0t read %h want %h", $time, regRdata & m, e);
         end
      end
      rdDly <= regRd;
   end
   // Hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 95000) begin
         mismatches++;
         $display("BAD %0t timeout", $time);
         stop_test;
      end
   end
   initial begin
      rst_n = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = '0; rdDly = 1'b0;
      regWdata = '0; selectA = 1'b1; ctlPins = '0; analogBelow = 1'b0;
      mode = 2'h0;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      chk(lockLoss === 1'b1 && clockSelect === CKS_REF, "reset lock");
      rd(LRD_ADDR_CTRL, {22'h0, CTL_RESET}, 32'hffffffff);
      wr(8'h0c, 32'h3ff);
      rd(8'h0c, 32'h0, 32'hffffffff);
      rd(LRD_ADDR_CTRL, {22'h0, CTL_RESET}, 32'hffffffff);
      $display("test registers done");
      wr(LRD_ADDR_CTRL, 32'h006);
      repeat (2) @(posedge core_clk);
      chk(eqEn === 1'b0 && monEn === 1'b1 && thrSel === 1'b1, "ctl");
      selectA <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         ctlPins <= CTL_WIDTH'($random(seed));
         repeat (8) @(posedge core_clk);
         chk(eqEn === ctlPins[0] && thrSel === ctlPins[2], "pins");
         chk(monEn === ctlPins[1], "pin gain");
      end
      selectA <= 1'b1;
      wr(LRD_ADDR_CTRL, 32'h001);
      $display("test controls done");
      mode <= 2'h1;
      for (n = 0; n < 40000 && lockLoss !== 1'b0; n++) @(posedge core_clk);
      @(posedge core_clk); // Clock select follows lock one edge later
      chk(lockLoss === 1'b0 && clockSelect === CKS_LINE, "lock");
      chk(rxData === lrd_sym_t'(2'h2), "decoded ones");
      mode <= 2'h2;
      seen = 1'b0;
      // Long enough that a counter without restart would reach 175 zeros
      for (n = 0; n < 2400; n++) begin
         @(posedge core_clk);
         seen = seen | (codeViolationPulse === 1'b1);
      end
      chk(seen === 1'b1, "no violation pulse");
      chk(receiveLos === 1'b0, "zero run did not restart");
      wr(LRD_ADDR_CTRL, 32'h081);
      seen = 1'b0;
      for (n = 0; n < 64; n++) begin
         @(posedge core_clk);
         seen = seen | (rxData.neg === 1'b1);
      end
      chk(seen === 1'b1, "dual rail not raw");
      $display("test decoder done");
      wr(LRD_ADDR_CTRL, 32'h021);
      mode <= 2'h0;
      for (n = 0; n < 1200 && receiveLos !== 1'b1; n++) @(posedge core_clk);
      chk(n >= 380 && n <= 1020, "digital loss timing");
      rd(LRD_ADDR_STATUS, 32'ha, 32'he);
      chk(clockSelect === CKS_REF && rxData === '0, "ref, mute");
      for (n = 0; n < 40000 && lockLoss !== 1'b1; n++) @(posedge core_clk);
      chk(lockLoss === 1'b1, "lock loss");
      wr(LRD_ADDR_CTRL, 32'h061);
      repeat (4) @(posedge core_clk);
      chk(clockSelect === CKS_SYNTH, "synth clock");
      mode <= 2'h1;
      for (n = 0; n < 1200 && receiveLos !== 1'b0; n++) @(posedge core_clk);
      chk(receiveLos === 1'b0, "digital loss clear");
      repeat (12) @(posedge core_clk);
      chk(rxData === lrd_sym_t'(2'h2), "data resumed");
      $display("test digital loss done");
      analogBelow <= 1'b1;
      repeat (10) @(posedge core_clk);
      chk(receiveLos === 1'b1, "analog or");
      chk(rxData === '0, "live data not muted");
      rd(LRD_ADDR_STATUS, 32'hc, 32'hc);
      wr(LRD_ADDR_CTRL, 32'h019);
      repeat (10) @(posedge core_clk);
      chk(receiveLos === 1'b0, "loss detect disabled");
      analogBelow <= 1'b0;
      wr(LRD_ADDR_CTRL, 32'h201);
      repeat (20) @(posedge core_clk);
      analogBelow <= 1'b1;
      for (n = 0; n < 1100 && receiveLos !== 1'b1; n++) @(posedge core_clk);
      chk(n >= 40 && n <= 1030, "E3 declare");
      analogBelow <= 1'b0;
      for (n = 0; n < 1100 && receiveLos !== 1'b0; n++) @(posedge core_clk);
      chk(n >= 40 && n <= 1030, "E3 clear");
      $display("test analog loss done");
      mode <= 2'h3;
      seen = 1'b0;
      for (n = 0; n < 64; n++) begin
         @(posedge core_clk);
         seen = seen | (codeViolationPulse === 1'b1);
      end
      chk(seen === 1'b1, "violation not flagged");
      chk(rxData === '0, "violation not decoded as zero");
      $display("test violations done");
      stop_test;
   end
endmodule
